// [hw/sld_regs.svh]
// register offsets, field positions and reset values of the synthetic loss and delay endpoint
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH
`define SLD_A_CTRL 8'h00
`define SLD_A_STICKY 8'h04
`define SLD_A_TXCNT 8'h08
`define SLD_A_MEPID 8'h0c
`define SLD_A_EXTR 8'h10
`define SLD_A_DOM_ANA 8'h14
`define SLD_A_DOM_REW 8'h18
`define SLD_PG_PEER 3'h1
`define SLD_PG_TXLM 3'h2
`define SLD_PG_RXLM 3'h3
`define SLD_CTRL_W 13
`define SLD_CTRL_RST 13'h0000
`define SLD_B_LM_HW 0
`define SLD_B_LR_HW 1
`define SLD_B_DM_HW 2
`define SLD_B_DR_HW 3
`define SLD_B_LM_CNT 4
`define SLD_B_LR_CNT 5
`define SLD_B_LM_LB 6
`define SLD_B_LM_CPU 7
`define SLD_B_LR_CPU 8
`define SLD_B_RX_INS 9
`define SLD_B_EXT_TS 10
`define SLD_B_UP_DIR 11
`define SLD_B_EXT_ONCE 12
`define SLD_ST_W 3
`define SLD_ST_RST 3'h0
`define SLD_B_ST_SLM 0
`define SLD_B_ST_SLR 1
`define SLD_B_ST_ONE 2
`define SLD_ID_W 13
`define SLD_B_PEER_EN 16
`define SLD_DOM_W 2
`define SLD_TLV_OFS 8'h14
`define SLD_END_TLV 8'h00
`define SLD_INC 32'h00000001
`endif

// [hw/sld_pkg.sv]
// types shared by the synthetic loss and delay endpoint
package sld_pkg;
  typedef enum logic [2:0] {
    SLD_PDU_SLM, SLD_PDU_SLR, SLD_PDU_ONE_SL,
    SLD_PDU_DMM, SLD_PDU_DMR, SLD_PDU_ONE_DM, SLD_PDU_OTHER
  } sld_pdu_e;
  typedef enum logic [1:0] {SLD_TS_PTP, SLD_TS_ANA, SLD_TS_REW} sld_ts_pt_e;
endpackage

// [hw/sld_peer_match.sv]
// peer list search: lowest enabled row whose identifier equals the key
`timescale 1ns/1ps
module sld_peer_match #(
  parameter int NUM_PEERS = 8,
  parameter int ID_W = 13,
  parameter int IDX_W = 3
) (
  input wire logic [NUM_PEERS-1:0] peer_en,
  input wire logic [NUM_PEERS*ID_W-1:0] peer_ids,
  input wire logic [ID_W-1:0] key,
  output logic hit,
  output logic [IDX_W-1:0] idx
);
  // scan from the top so the lowest matching row is kept
  always_comb begin
    hit = 1'b0;
    idx = '0;
    for (int i = NUM_PEERS - 1; i >= 0; i--) begin
      if (peer_en[i] && peer_ids[i*ID_W +: ID_W] == key) begin
        hit = 1'b1;
        idx = IDX_W'(i);
      end
    end
  end
endmodule // sld_peer_match

// [hw/sld_oam_endpoint.sv]
// frame lookup logic of one oam_endpoint for synthetic loss and delay frames
`timescale 1ns/1ps
`include "sld_regs.svh"
module sld_oam_endpoint
  import sld_pkg::*;
#(
  parameter int NUM_PEERS = 8,
  parameter int NUM_PORTS = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic lkp_valid,
  input wire logic lkp_tx,
  input wire sld_pdu_e lkp_pdu,
  input wire logic [`SLD_ID_W-1:0] lkp_peer_mepid,
  input wire logic [`SLD_ID_W-1:0] lkp_src_mepid,
  input wire logic [$clog2(NUM_PORTS)-1:0] lkp_port,
  output logic res_valid,
  output logic res_frame_ok,
  output logic res_field_wr,
  output logic [31:0] res_fc_value,
  output logic res_rxfc_insert,
  output logic [7:0] res_tlv_offset,
  output logic [7:0] res_end_tlv,
  output logic res_rsp_mepid_wr,
  output logic [`SLD_ID_W-1:0] res_rsp_mepid,
  output logic res_loop_reply,
  output logic res_cpu_copy,
  output logic res_oam_selected,
  output logic res_flm_count,
  output logic res_ts_update,
  output sld_ts_pt_e res_ts_point,
  output logic [`SLD_DOM_W-1:0] res_ts_domain
);
  localparam int PIDX_W = $clog2(NUM_PEERS);
  localparam int DOMS_W = NUM_PORTS * `SLD_DOM_W;

  // the peer window holds eight words and a domain word holds sixteen ports
  if (NUM_PEERS < 2 || NUM_PEERS > 8 || NUM_PORTS < 2 || DOMS_W > 32) begin : g_bad_param
    $error("sld_oam_endpoint: unsupported peer or port count");
  end

  //////////////////////////////////////////////////////////////////////////////
  // register decode
  logic [2:0] pg;
  logic [2:0] wsel;
  logic sel_ok;
  logic [PIDX_W-1:0] widx;
  assign pg = reg_addr[7:5];
  assign wsel = reg_addr[4:2];
  assign sel_ok = (int'(wsel) < NUM_PEERS) && (reg_addr[1:0] == 2'h0);
  assign widx = wsel[PIDX_W-1:0];

  logic wr_ctrl, wr_sticky, wr_txcnt, wr_mepid, wr_extr, wr_dana, wr_drew;
  logic wr_peer, wr_txlm, wr_rxlm;
  assign wr_ctrl = reg_wr && reg_addr == `SLD_A_CTRL;
  assign wr_sticky = reg_wr && reg_addr == `SLD_A_STICKY;
  assign wr_txcnt = reg_wr && reg_addr == `SLD_A_TXCNT;
  assign wr_mepid = reg_wr && reg_addr == `SLD_A_MEPID;
  assign wr_extr = reg_wr && reg_addr == `SLD_A_EXTR;
  assign wr_dana = reg_wr && reg_addr == `SLD_A_DOM_ANA;
  assign wr_drew = reg_wr && reg_addr == `SLD_A_DOM_REW;
  assign wr_peer = reg_wr && pg == `SLD_PG_PEER && sel_ok;
  assign wr_txlm = reg_wr && pg == `SLD_PG_TXLM && sel_ok;
  assign wr_rxlm = reg_wr && pg == `SLD_PG_RXLM && sel_ok;

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [`SLD_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [`SLD_ID_W-1:0] mepid_r, mepid_nxt;
  logic [NUM_PEERS-1:0] peer_en_r, peer_en_nxt;
  logic [NUM_PEERS*`SLD_ID_W-1:0] peer_id_r, peer_id_nxt;
  logic [DOMS_W-1:0] dana_r, dana_nxt;
  logic [DOMS_W-1:0] drew_r, drew_nxt;

  // software alone writes these; nothing in the lookup path changes them
  always_comb begin
    ctrl_nxt = ctrl_r;
    mepid_nxt = mepid_r;
    peer_en_nxt = peer_en_r;
    peer_id_nxt = peer_id_r;
    dana_nxt = dana_r;
    drew_nxt = drew_r;
    if (wr_ctrl) ctrl_nxt = reg_wdata[`SLD_CTRL_W-1:0];
    if (wr_mepid) mepid_nxt = reg_wdata[`SLD_ID_W-1:0];
    if (wr_peer) begin
      peer_en_nxt[widx] = reg_wdata[`SLD_B_PEER_EN];
      peer_id_nxt[widx*`SLD_ID_W +: `SLD_ID_W] = reg_wdata[`SLD_ID_W-1:0];
    end
    // one domain per port on each side; software keeps both maps alike
    if (wr_dana) dana_nxt = reg_wdata[DOMS_W-1:0];
    if (wr_drew) drew_nxt = reg_wdata[DOMS_W-1:0];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `SLD_CTRL_RST;
      mepid_r <= '0;
      peer_en_r <= '0;
      peer_id_r <= '0;
      dana_r <= '0;
      drew_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      mepid_r <= mepid_nxt;
      peer_en_r <= peer_en_nxt;
      peer_id_r <= peer_id_nxt;
      dana_r <= dana_nxt;
      drew_r <= drew_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // lookup: classify, validate and decide every action of the frame
  logic peer_hit;
  logic [PIDX_W-1:0] peer_index;

  sld_peer_match #(
    .NUM_PEERS(NUM_PEERS),
    .ID_W(`SLD_ID_W),
    .IDX_W(PIDX_W)
  ) u_peer (
    .peer_en(peer_en_r),
    .peer_ids(peer_id_r),
    .key(lkp_peer_mepid),
    .hit(peer_hit),
    .idx(peer_index)
  );

  logic [31:0] txcnt_r, txcnt_nxt;
  logic [31:0] txlm_r [NUM_PEERS];
  logic [31:0] txlm_nxt [NUM_PEERS];
  logic [31:0] rxlm_r [NUM_PEERS];
  logic [31:0] rxlm_nxt [NUM_PEERS];
  logic [NUM_PEERS-1:0] extr_r, extr_nxt;

  logic is_slm, is_slr, is_one, is_sl, sl_ok, hw_en, dm_en;
  logic ev_txcnt, ev_txlm, ev_rxlm, ev_extr_clr;
  logic [`SLD_ST_W-1:0] ev_sticky;
  logic ok_nxt, fwr_nxt, ins_nxt, rsp_nxt, loop_nxt, cpu_nxt, oam_nxt, flm_nxt, ts_nxt;
  logic [31:0] fc_nxt;
  logic [7:0] tlv_nxt, endt_nxt;
  sld_ts_pt_e tsp_nxt;
  logic [`SLD_DOM_W-1:0] dom_nxt;

  assign is_slm = lkp_pdu == SLD_PDU_SLM;
  assign is_slr = lkp_pdu == SLD_PDU_SLR;
  assign is_one = lkp_pdu == SLD_PDU_ONE_SL;
  assign is_sl = is_slm || is_slr || is_one;
  // a received reply must also name this endpoint as its source
  assign sl_ok = lkp_valid && is_sl && peer_hit &&
                 (lkp_tx || !is_slr || lkp_src_mepid == mepid_r);
  assign hw_en = is_slm ? ctrl_r[`SLD_B_LM_HW] : ctrl_r[`SLD_B_LR_HW];
  // one-way delay frames share the message enable
  assign dm_en = (lkp_pdu == SLD_PDU_DMR) ? ctrl_r[`SLD_B_DR_HW] : ctrl_r[`SLD_B_DM_HW];

  // counters step even with processing off: only the frame edits are gated
  always_comb begin
    ok_nxt = 1'b0;
    fwr_nxt = 1'b0;
    fc_nxt = 32'h0;
    ins_nxt = 1'b0;
    tlv_nxt = 8'h0;
    endt_nxt = 8'h0;
    rsp_nxt = 1'b0;
    loop_nxt = 1'b0;
    cpu_nxt = 1'b0;
    oam_nxt = 1'b0;
    flm_nxt = 1'b0;
    ts_nxt = 1'b0;
    tsp_nxt = SLD_TS_PTP;
    dom_nxt = '0;
    ev_txcnt = 1'b0;
    ev_txlm = 1'b0;
    ev_rxlm = 1'b0;
    ev_extr_clr = 1'b0;
    ev_sticky = '0;
    if (sl_ok) begin
      ok_nxt = 1'b1;
      oam_nxt = is_slm ? ctrl_r[`SLD_B_LM_CNT] : ctrl_r[`SLD_B_LR_CNT];
      flm_nxt = is_slm || is_slr;
      if (lkp_tx && !is_slr) begin
        fc_nxt = txcnt_r;
        fwr_nxt = hw_en;
        ev_txcnt = 1'b1;
      end else if (lkp_tx) begin
        fc_nxt = txlm_r[peer_index];
        fwr_nxt = hw_en;
        rsp_nxt = hw_en;
        ev_txlm = 1'b1;
      end else if (is_slm) begin
        ev_sticky[`SLD_B_ST_SLM] = 1'b1;
        loop_nxt = ctrl_r[`SLD_B_LM_LB] && hw_en;
        cpu_nxt = ctrl_r[`SLD_B_LM_CPU];
      end else begin
        ev_rxlm = 1'b1;
        fc_nxt = rxlm_r[peer_index];
        if (is_slr) begin
          ev_sticky[`SLD_B_ST_SLR] = 1'b1;
          ins_nxt = ctrl_r[`SLD_B_RX_INS] && hw_en;
          fwr_nxt = ins_nxt;
          tlv_nxt = ins_nxt ? `SLD_TLV_OFS : 8'h0;
          endt_nxt = `SLD_END_TLV;
        end else begin
          ev_sticky[`SLD_B_ST_ONE] = 1'b1;
          fwr_nxt = hw_en;
        end
        // per-peer extraction, disarmed after one hit in once mode
        cpu_nxt = ctrl_r[`SLD_B_LR_CPU] || extr_r[peer_index];
        ev_extr_clr = extr_r[peer_index] && ctrl_r[`SLD_B_EXT_ONCE];
      end
    end else if (lkp_valid && !is_sl) begin
      ok_nxt = lkp_pdu != SLD_PDU_OTHER;
      // delay frames are still looped and extracted elsewhere; only stamps stop
      ts_nxt = ok_nxt && dm_en && !ctrl_r[`SLD_B_EXT_TS];
      if (ctrl_r[`SLD_B_UP_DIR]) begin
        tsp_nxt = lkp_tx ? SLD_TS_ANA : SLD_TS_REW;
      end
      dom_nxt = lkp_tx ? dana_r[{lkp_port, 1'b0} +: `SLD_DOM_W]
                       : drew_r[{lkp_port, 1'b0} +: `SLD_DOM_W];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // lookup result, presented the cycle after the lookup
  logic vld_r;
  logic ok_r, fwr_r, ins_r, rsp_r, loop_r, cpu_r, oam_r, flm_r, ts_r;
  logic [31:0] fc_r;
  logic [7:0] tlv_r, endt_r;
  sld_ts_pt_e tsp_r;
  logic [`SLD_DOM_W-1:0] dom_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      vld_r <= 1'b0;
      ok_r <= 1'b0;
      fwr_r <= 1'b0;
      fc_r <= 32'h0;
      ins_r <= 1'b0;
      tlv_r <= 8'h0;
      endt_r <= 8'h0;
      rsp_r <= 1'b0;
      loop_r <= 1'b0;
      cpu_r <= 1'b0;
      oam_r <= 1'b0;
      flm_r <= 1'b0;
      ts_r <= 1'b0;
      tsp_r <= SLD_TS_PTP;
      dom_r <= '0;
    end else begin
      vld_r <= lkp_valid;
      ok_r <= ok_nxt;
      fwr_r <= fwr_nxt;
      fc_r <= fc_nxt;
      ins_r <= ins_nxt;
      tlv_r <= tlv_nxt;
      endt_r <= endt_nxt;
      rsp_r <= rsp_nxt;
      loop_r <= loop_nxt;
      cpu_r <= cpu_nxt;
      oam_r <= oam_nxt;
      flm_r <= flm_nxt;
      ts_r <= ts_nxt;
      tsp_r <= tsp_nxt;
      dom_r <= dom_nxt;
    end
  end

  assign res_valid = vld_r;
  assign res_frame_ok = ok_r;
  assign res_field_wr = fwr_r;
  assign res_fc_value = fc_r;
  assign res_rxfc_insert = ins_r;
  assign res_tlv_offset = tlv_r;
  assign res_end_tlv = endt_r;
  assign res_rsp_mepid_wr = rsp_r;
  assign res_loop_reply = loop_r;
  assign res_cpu_copy = cpu_r;
  assign res_oam_selected = oam_r;
  assign res_flm_count = flm_r;
  assign res_ts_update = ts_r;
  assign res_ts_point = tsp_r;
  assign res_ts_domain = dom_r;

  // responder id comes straight from the local id register
  assign res_rsp_mepid = mepid_r;

  //////////////////////////////////////////////////////////////////////////////
  // counters, receive flags and extraction arming
  logic [`SLD_ST_W-1:0] sticky_r, sticky_nxt;

  // a software write beats a same-cycle step; a hardware set beats a clear
  always_comb begin
    txcnt_nxt = ev_txcnt ? txcnt_r + `SLD_INC : txcnt_r;
    if (wr_txcnt) txcnt_nxt = reg_wdata;
    for (int i = 0; i < NUM_PEERS; i++) begin
      txlm_nxt[i] = txlm_r[i];
      rxlm_nxt[i] = rxlm_r[i];
      if (ev_txlm && peer_index == PIDX_W'(i)) txlm_nxt[i] = txlm_r[i] + `SLD_INC;
      if (ev_rxlm && peer_index == PIDX_W'(i)) rxlm_nxt[i] = rxlm_r[i] + `SLD_INC;
      if (wr_txlm && widx == PIDX_W'(i)) txlm_nxt[i] = reg_wdata;
      if (wr_rxlm && widx == PIDX_W'(i)) rxlm_nxt[i] = reg_wdata;
    end
    sticky_nxt = wr_sticky ? sticky_r & ~reg_wdata[`SLD_ST_W-1:0] : sticky_r;
    sticky_nxt = sticky_nxt | ev_sticky;
    extr_nxt = extr_r;
    if (ev_extr_clr) extr_nxt[peer_index] = 1'b0;
    if (wr_extr) extr_nxt = reg_wdata[NUM_PEERS-1:0];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txcnt_r <= 32'h0;
      sticky_r <= `SLD_ST_RST;
      extr_r <= '0;
      for (int i = 0; i < NUM_PEERS; i++) begin
        txlm_r[i] <= 32'h0;
        rxlm_r[i] <= 32'h0;
      end
    end else begin
      txcnt_r <= txcnt_nxt;
      sticky_r <= sticky_nxt;
      extr_r <= extr_nxt;
      for (int i = 0; i < NUM_PEERS; i++) begin
        txlm_r[i] <= txlm_nxt[i];
        rxlm_r[i] <= rxlm_nxt[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data: valid only in the cycle after the read strobe, zero otherwise
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `SLD_A_CTRL: rdata_nxt[`SLD_CTRL_W-1:0] = ctrl_r;
        `SLD_A_STICKY: rdata_nxt[`SLD_ST_W-1:0] = sticky_r;
        `SLD_A_TXCNT: rdata_nxt = txcnt_r;
        `SLD_A_MEPID: rdata_nxt[`SLD_ID_W-1:0] = mepid_r;
        `SLD_A_EXTR: rdata_nxt[NUM_PEERS-1:0] = extr_r;
        `SLD_A_DOM_ANA: rdata_nxt[DOMS_W-1:0] = dana_r;
        `SLD_A_DOM_REW: rdata_nxt[DOMS_W-1:0] = drew_r;
        default: begin
          if (sel_ok && pg == `SLD_PG_PEER) begin
            rdata_nxt[`SLD_B_PEER_EN] = peer_en_r[widx];
            rdata_nxt[`SLD_ID_W-1:0] = peer_id_r[widx*`SLD_ID_W +: `SLD_ID_W];
          end else if (sel_ok && pg == `SLD_PG_TXLM) begin
            rdata_nxt = txlm_r[widx];
          end else if (sel_ok && pg == `SLD_PG_RXLM) begin
            rdata_nxt = rxlm_r[widx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
endmodule // sld_oam_endpoint

// [tb/sld_oam_endpoint_monitor.sv]
// concurrent checks on the lookup result ports of the endpoint
`timescale 1ns/1ps
module sld_oam_endpoint_monitor
  import sld_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic lkp_valid,
  input wire logic lkp_tx,
  input wire sld_pdu_e lkp_pdu,
  input wire logic res_valid,
  input wire logic res_frame_ok,
  input wire logic res_rxfc_insert,
  input wire logic [7:0] res_tlv_offset,
  input wire logic res_rsp_mepid_wr,
  input wire logic res_loop_reply,
  input wire logic res_cpu_copy,
  input wire logic res_flm_count,
  input wire logic res_ts_update,
  input wire sld_ts_pt_e res_ts_point
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // each lookup answers in exactly the next cycle, so counters settle per frame
  AST_RES_ONE: assert property (res_valid == $past(lkp_valid))
    else $error("result pulse not one cycle after lookup");
  AST_TLV_OFS: assert property (res_tlv_offset == (res_rxfc_insert ? 8'h14 : 8'h00))
    else $error("tlv offset does not follow count insertion");
  AST_INS_SRC: assert property (res_rxfc_insert |-> !$past(lkp_tx) && $past(lkp_pdu) == SLD_PDU_SLR)
    else $error("count inserted into a frame other than a received reply");
  AST_FLM: assert property (lkp_valid && (lkp_pdu == SLD_PDU_SLM || lkp_pdu == SLD_PDU_SLR)
    ##1 res_frame_ok |-> res_flm_count)
    else $error("valid synthetic frame missed the loss counters");
  AST_RSP_ID: assert property (res_rsp_mepid_wr |-> $past(lkp_tx) && $past(lkp_pdu) == SLD_PDU_SLR)
    else $error("responder id written outside a sent reply");
  AST_LOOP: assert property (res_loop_reply |-> !$past(lkp_tx) && $past(lkp_pdu) == SLD_PDU_SLM
    && res_frame_ok)
    else $error("loop reply without a valid received message");
  AST_COPY: assert property (res_cpu_copy |-> !$past(lkp_tx) && res_frame_ok)
    else $error("processor copy of an invalid or sent frame");
  AST_TS_DLY: assert property (res_ts_update |->
    $past(lkp_pdu) inside {SLD_PDU_DMM, SLD_PDU_DMR, SLD_PDU_ONE_DM})
    else $error("time stamp update on a non delay frame");
  AST_TS_PT: assert property (res_ts_update |->
    res_ts_point != ($past(lkp_tx) ? SLD_TS_REW : SLD_TS_ANA))
    else $error("stamp point on the wrong modifier side");
endmodule // sld_oam_endpoint_monitor

// [tb/sld_peer_model.sv]
// far-side peer endpoint model: turns frame requests into lookups
`timescale 1ns/1ps
module sld_peer_model
  import sld_pkg::*;
(
  input wire logic core_clk,
  input wire logic rq,
  input wire logic rtx,
  input wire sld_pdu_e rpdu,
  input wire logic [12:0] rpeer,
  output logic lkp_valid,
  output logic lkp_tx,
  output sld_pdu_e lkp_pdu,
  output logic [12:0] lkp_peer_mepid,
  output logic [12:0] lkp_src_mepid
);
  // quiet start so the lookup port is defined at time zero
  initial begin
    lkp_valid = 1'b0;
    lkp_tx = 1'b0;
    lkp_pdu = SLD_PDU_OTHER;
    lkp_peer_mepid = 13'h0000;
    lkp_src_mepid = 13'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // idle fields toggle so a stale id can never pass for a fresh one
  always @(posedge core_clk) begin
    lkp_valid <= rq;
    lkp_tx <= rq ? rtx : ~lkp_tx;
    lkp_pdu <= rq ? rpdu : SLD_PDU_OTHER;
    lkp_peer_mepid <= rq ? rpeer : ~lkp_peer_mepid;
    lkp_src_mepid <= rq ? 13'h0055 : ~lkp_src_mepid;
  end
endmodule // sld_peer_model

// [tb/test_synthetic_loss_delay_oam.sv]
// self-checking bench of the synthetic loss and delay endpoint
`timescale 1ns/1ps
module test_synthetic_loss_delay_oam
  import sld_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, res_fc_value;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rq = 1'b0, rtx = 1'b0;
  logic [2:0] port = 3'h1;
  sld_pdu_e rpdu = SLD_PDU_OTHER, lkp_pdu;
  logic [12:0] rpeer = 13'h0000, lkp_peer_mepid, lkp_src_mepid, res_rsp_mepid;
  logic lkp_valid, lkp_tx, res_valid, res_frame_ok, res_field_wr, res_rxfc_insert;
  logic res_rsp_mepid_wr, res_loop_reply, res_cpu_copy, res_oam_selected, res_flm_count;
  logic res_ts_update;
  logic [7:0] res_tlv_offset, res_end_tlv;
  logic [1:0] res_ts_domain;
  sld_ts_pt_e res_ts_point;
  int mismatches = 0, checked = 0;
  always #2 core_clk = ~core_clk;
  sld_peer_model sld_peer_model_inst (.core_clk(core_clk), .rq(rq), .rtx(rtx), .rpdu(rpdu),
    .rpeer(rpeer), .lkp_valid(lkp_valid), .lkp_tx(lkp_tx), .lkp_pdu(lkp_pdu),
    .lkp_peer_mepid(lkp_peer_mepid), .lkp_src_mepid(lkp_src_mepid));
  sld_oam_endpoint sld_oam_endpoint_inst (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lkp_valid(lkp_valid), .lkp_tx(lkp_tx), .lkp_pdu(lkp_pdu),
    .lkp_peer_mepid(lkp_peer_mepid), .lkp_src_mepid(lkp_src_mepid), .lkp_port(port),
    .res_valid(res_valid), .res_frame_ok(res_frame_ok), .res_field_wr(res_field_wr),
    .res_fc_value(res_fc_value), .res_rxfc_insert(res_rxfc_insert),
    .res_tlv_offset(res_tlv_offset), .res_end_tlv(res_end_tlv),
    .res_rsp_mepid_wr(res_rsp_mepid_wr), .res_rsp_mepid(res_rsp_mepid),
    .res_loop_reply(res_loop_reply), .res_cpu_copy(res_cpu_copy),
    .res_oam_selected(res_oam_selected), .res_flm_count(res_flm_count),
    .res_ts_update(res_ts_update), .res_ts_point(res_ts_point),
    .res_ts_domain(res_ts_domain));
  ////////////////////////////////////////////////////////////////////////////////
  // compare, verdict and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // one frame through the peer model; returns while the result stands
  task automatic fr(input logic tx, input sld_pdu_e p, input logic [12:0] id);
    @(posedge core_clk);
    rq <= 1'b1;
    rtx <= tx;
    rpdu <= p;
    rpeer <= id;
    @(posedge core_clk);
    rq <= 1'b0;
    @(posedge core_clk);
    #1 chk(res_valid, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_regs;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'hfc, 32'h0);
    wr(8'h0c, 32'h55);
    wr(8'h20, 32'h10123);
  endtask
  task t_tx_slm;
    wr(8'h08, 32'h5);
    wr(8'h00, 32'h11);
    fr(1'b1, SLD_PDU_SLM, 13'h0123);
    chk(res_field_wr, 1'b1);
    chk(res_fc_value, 32'h5);
    chk(res_oam_selected, 1'b1);
    fr(1'b1, SLD_PDU_SLM, 13'h0123);
    chk(res_fc_value, 32'h6);
    wr(8'h00, 32'h0);
    fr(1'b1, SLD_PDU_SLM, 13'h0123);
    chk(res_field_wr, 1'b0);
    chk(res_oam_selected, 1'b0);
    chk(res_flm_count, 1'b1);
    rd(8'h08, 32'h8);
  endtask
  task t_tx_1sl;
    wr(8'h00, 32'h2);
    fr(1'b1, SLD_PDU_ONE_SL, 13'h0123);
    chk(res_fc_value, 32'h8);
    rd(8'h08, 32'h9);
  endtask
  task t_rx_slm;
    wr(8'h00, 32'hc1);
    fr(1'b0, SLD_PDU_SLM, 13'h0123);
    chk(res_loop_reply, 1'b1);
    chk(res_cpu_copy, 1'b1);
    rd(8'h04, 32'h1);
    rd(8'h04, 32'h1);
    wr(8'h04, 32'h1);
    fr(1'b0, SLD_PDU_SLM, 13'h0777);
    chk(res_frame_ok, 1'b0);
    chk(res_loop_reply, 1'b0);
    rd(8'h04, 32'h0);
  endtask
  task t_tx_slr;
    wr(8'h40, 32'h10);
    wr(8'h00, 32'h2);
    fr(1'b1, SLD_PDU_SLR, 13'h0123);
    chk(res_fc_value, 32'h10);
    chk(res_rsp_mepid_wr, 1'b1);
    chk(res_rsp_mepid, 32'h55);
    rd(8'h40, 32'h11);
  endtask
  task t_rx_slr;
    wr(8'h60, 32'h20);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h1202);
    fr(1'b0, SLD_PDU_SLR, 13'h0123);
    chk(res_rxfc_insert, 1'b1);
    chk(res_tlv_offset, 8'h14);
    chk(res_end_tlv, 8'h00);
    chk(res_fc_value, 32'h20);
    chk(res_cpu_copy, 1'b1);
    fr(1'b0, SLD_PDU_SLR, 13'h0123);
    chk(res_fc_value, 32'h21);
    chk(res_cpu_copy, 1'b0);
    rd(8'h04, 32'h2);
    wr(8'h00, 32'h102);
    fr(1'b0, SLD_PDU_SLR, 13'h0123);
    chk(res_cpu_copy, 1'b1);
  endtask
  // received dual-ended traffic only after the single-ended session is over
  task t_rx_1sl;
    fr(1'b0, SLD_PDU_ONE_SL, 13'h0123);
    chk(res_field_wr, 1'b1);
    chk(res_fc_value, 32'h23);
    chk(res_cpu_copy, 1'b1);
    rd(8'h04, 32'h6);
    rd(8'h60, 32'h24);
  endtask
  task t_dm;
    wr(8'h14, 32'h18);
    wr(8'h18, 32'h18);
    wr(8'h00, 32'h80c);
    fr(1'b1, SLD_PDU_DMM, 13'h0123);
    chk(res_ts_update, 1'b1);
    chk(res_ts_point, SLD_TS_ANA);
    chk(res_ts_domain, 2'h2);
    // second port sits in another domain, so the map really is indexed by port
    @(posedge core_clk) port <= 3'h2;
    fr(1'b0, SLD_PDU_DMR, 13'h0123);
    chk(res_ts_point, SLD_TS_REW);
    chk(res_ts_domain, 2'h1);
    wr(8'h00, 32'hc);
    fr(1'b1, SLD_PDU_ONE_DM, 13'h0123);
    chk(res_ts_point, SLD_TS_PTP);
    wr(8'h00, 32'hc0c);
    fr(1'b0, SLD_PDU_DMM, 13'h0123);
    chk(res_ts_update, 1'b0);
    chk(res_frame_ok, 1'b1);
    wr(8'h00, 32'h4);
    fr(1'b1, SLD_PDU_DMR, 13'h0123);
    chk(res_ts_update, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog; the run takes well under a thousand cycles
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs;
    t_tx_slm;
    t_tx_1sl;
    t_rx_slm;
    t_tx_slr;
    t_rx_slr;
    t_rx_1sl;
    t_dm;
    final_report;
  end
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
endmodule // test_synthetic_loss_delay_oam
bind sld_oam_endpoint sld_oam_endpoint_monitor sld_oam_endpoint_monitor_inst (
  .core_clk(core_clk), .rstn(rstn), .lkp_valid(lkp_valid), .lkp_tx(lkp_tx),
  .lkp_pdu(lkp_pdu), .res_valid(res_valid), .res_frame_ok(res_frame_ok),
  .res_rxfc_insert(res_rxfc_insert), .res_tlv_offset(res_tlv_offset),
  .res_rsp_mepid_wr(res_rsp_mepid_wr), .res_loop_reply(res_loop_reply),
  .res_cpu_copy(res_cpu_copy), .res_flm_count(res_flm_count),
  .res_ts_update(res_ts_update), .res_ts_point(res_ts_point));
